//--- core/sec_pkg.sv
// package: register map, field layout and constants of the exception control
package sec_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [31:0] SEC_ADDR_RST_CTRL = 32'he000ed0c;
    localparam logic [31:0] SEC_ADDR_PRI_FAULT = 32'he000ed18;
    localparam logic [31:0] SEC_ADDR_PRI_SVC = 32'he000ed1c;
    localparam logic [31:0] SEC_ADDR_PRI_TICK = 32'he000ed20;
    localparam logic [31:0] SEC_ADDR_HND_CTRL = 32'he000ed24;
    localparam logic [31:0] SEC_ADDR_IRQ_STAT = 32'he000ed80;
    localparam logic [31:0] SEC_ADDR_IRQ_EN = 32'he000ed84;
    localparam logic [31:0] SEC_ADDR_IRQ_CLR = 32'he000ed88;
    // ****************************************
    // reset control fields
    // ****************************************
    localparam logic [15:0] SEC_KEY_WRITE = 16'h05fa;
    localparam logic [15:0] SEC_KEY_READ = 16'hfa05;
    localparam int SEC_BIT_LOCAL_RST = 0;
    localparam int SEC_BIT_CLR_ACT = 1;
    localparam int SEC_BIT_CHIP_RST = 2;
    localparam int SEC_BIT_ORDER = 15;
    localparam logic SEC_ORDER_LITTLE = 1'b0;
    // ****************************************
    // priority fields: three bits at the top of each handler's byte
    // ****************************************
    localparam int SEC_PRI_BITS = 3;
    localparam logic [31:0] SEC_PRI_MASK_FAULT = 32'he0e0e0e0;
    localparam logic [31:0] SEC_PRI_MASK_SVC = 32'he0000000;
    localparam logic [31:0] SEC_PRI_MASK_TICK = 32'he0e000e0;
    localparam logic [31:0] SEC_PRI_RESET = 32'h00000000;
    // ****************************************
    // handler control and state fields
    // ****************************************
    localparam logic [31:0] SEC_HND_MASK = 32'h0007fd8b;
    localparam logic [31:0] SEC_HND_ACT_MASK = 32'h00000d8b;
    localparam logic [31:0] SEC_HND_PEND_MASK = 32'h0000f000;
    localparam logic [31:0] SEC_HND_RESET = 32'h00000000;
    localparam int SEC_EV_W = 3;
    localparam int SEC_EV_CHIP = 0;
    localparam int SEC_EV_LOCAL = 1;
    localparam int SEC_EV_CLR = 2;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } sec_bus_req_t;

    typedef struct packed {
        logic [3:0] pend_set;
        logic [6:0] act_set;
        logic [6:0] act_clr;
    } sec_core_ev_t;
endpackage : sec_pkg

//--- core/sec_system_exception_control.sv
// system exception control registers: reset control, priorities, handler state
`timescale 1ns/100ps

// How it works
// - bit 2 write raises chip reset request
// - request held until warm reset clears it
// - bit 1 clears all active state, self-clears
// - bit 0 local reset, reads back zero
// - byte order flag reads little-endian
// - reset control bits 7..3 read zero
// - one byte per handler, three top bits
// - low five priority bits read zero
// - priority bytes mapped across three words
// - first word top field stored, unused
// - fault enable bits at 18..16
// - pending bits at 15..12, read-write
// - active bits at 11,10,8,7,3,1,0
// - handler control unused bits read zero
// - reset control write needs key
module sec_system_exception_control
    import sec_pkg::*;
(
    // clock and reset
    input wire logic CLK_SYS_I,
    input wire logic SRST_I,
    // register port
    input wire logic [31:0] ADDR_I,
    input wire logic [31:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [31:0] RDATA_O,
    // core exception events
    input wire logic [3:0] PEND_SET_I,
    input wire logic [6:0] ACT_SET_I,
    input wire logic [6:0] ACT_CLR_I,
    // reset and state outputs
    output logic CHIP_RESET_REQUEST_O,
    output logic LOCAL_SYSTEM_RESET_O,
    output logic CLEAR_ACTIVE_STATE_O,
    output logic [2:0] FAULT_ENABLE_O,
    output logic [3:0] PENDING_O,
    output logic [6:0] ACTIVE_O,
    output logic [31:0] PRI_FAULT_O,
    output logic [31:0] PRI_SVC_O,
    output logic [31:0] PRI_TICK_O,
    // interrupt
    output logic IRQ_O
);
    // ****************************************
    // bus decode
    // ****************************************
    sec_bus_req_t req;
    sec_core_ev_t ev;
    assign req = '{addr: ADDR_I, wdata: WDATA_I, wr: WR_I, rd: RD_I};
    assign ev = '{pend_set: PEND_SET_I, act_set: ACT_SET_I,
                  act_clr: ACT_CLR_I};

    logic wr_rst, wr_pf, wr_ps, wr_pt, wr_hnd, wr_ien, wr_iclr, key_ok;
    assign wr_rst = req.wr && (req.addr == SEC_ADDR_RST_CTRL);
    assign wr_pf = req.wr && (req.addr == SEC_ADDR_PRI_FAULT);
    assign wr_ps = req.wr && (req.addr == SEC_ADDR_PRI_SVC);
    assign wr_pt = req.wr && (req.addr == SEC_ADDR_PRI_TICK);
    assign wr_hnd = req.wr && (req.addr == SEC_ADDR_HND_CTRL);
    assign wr_ien = req.wr && (req.addr == SEC_ADDR_IRQ_EN);
    assign wr_iclr = req.wr && (req.addr == SEC_ADDR_IRQ_CLR);
    assign key_ok = (req.wdata[31:16] == SEC_KEY_WRITE);

    logic do_chip, do_local, do_clr;
    assign do_chip = wr_rst && key_ok && req.wdata[SEC_BIT_CHIP_RST];
    assign do_local = wr_rst && key_ok && req.wdata[SEC_BIT_LOCAL_RST];
    assign do_clr = wr_rst && key_ok && req.wdata[SEC_BIT_CLR_ACT];

    // ****************************************
    // reset control
    // ****************************************
    logic chip_req_r, local_rst_r, clr_act_r;

    // request stays until warm reset (SRST_I) clears it
    always_ff @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            chip_req_r <= 1'b0;
        end else if (do_chip) begin
            chip_req_r <= 1'b1;
        end
    end

    // one-cycle pulses, so both bits self-clear
    always_ff @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            local_rst_r <= 1'b0;
            clr_act_r <= 1'b0;
        end else begin
            local_rst_r <= do_local;
            clr_act_r <= do_clr;
        end
    end

    // ****************************************
    // priority words
    // ****************************************
    logic [31:0] pri_fault_r, pri_svc_r, pri_tick_r;

    always_ff @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            pri_fault_r <= SEC_PRI_RESET;
            pri_svc_r <= SEC_PRI_RESET;
            pri_tick_r <= SEC_PRI_RESET;
        end else begin
            // top field of first word kept though unassigned
            if (wr_pf) begin
                pri_fault_r <= req.wdata & SEC_PRI_MASK_FAULT;
            end
            if (wr_ps) begin
                pri_svc_r <= req.wdata & SEC_PRI_MASK_SVC;
            end
            if (wr_pt) begin
                pri_tick_r <= req.wdata & SEC_PRI_MASK_TICK;
            end
        end
    end

    // ****************************************
    // handler control and state
    // ****************************************
    logic [31:0] hnd_r, hnd_nxt;
    logic [31:0] pend_set_w, act_set_w, act_clr_w;

    // event vectors placed at the register's bit positions
    assign pend_set_w = {16'h0000, ev.pend_set, 12'h000};
    assign act_set_w = {20'h00000, ev.act_set[6:5], 1'b0, ev.act_set[4:3],
                        3'h0, ev.act_set[2], 1'b0, ev.act_set[1:0]};
    assign act_clr_w = {20'h00000, ev.act_clr[6:5], 1'b0, ev.act_clr[4:3],
                        3'h0, ev.act_clr[2], 1'b0, ev.act_clr[1:0]};

    always_comb begin
        hnd_nxt = hnd_r;
        if (wr_hnd) begin
            hnd_nxt = req.wdata & SEC_HND_MASK;
        end
        if (clr_act_r) begin
            hnd_nxt = hnd_nxt & ~SEC_HND_ACT_MASK;
        end
        hnd_nxt = hnd_nxt & ~act_clr_w;
        // hardware set wins over a clear in the same cycle
        hnd_nxt = hnd_nxt | pend_set_w | act_set_w;
        hnd_nxt = hnd_nxt & SEC_HND_MASK;
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            hnd_r <= SEC_HND_RESET;
        end else begin
            hnd_r <= hnd_nxt;
        end
    end

    // ****************************************
    // interrupt status
    // ****************************************
    logic [SEC_EV_W-1:0] ist_r, ien_r, ev_w;
    assign ev_w = {do_clr, do_local, do_chip};

    always_ff @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            ist_r <= '0;
        end else begin
            ist_r <= (ist_r & ~(wr_iclr ? req.wdata[SEC_EV_W-1:0] : '0))
                     | ev_w;
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            ien_r <= '0;
        end else if (wr_ien) begin
            ien_r <= req.wdata[SEC_EV_W-1:0];
        end
    end

    // ****************************************
    // read path
    // ****************************************
    always_ff @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            RDATA_O <= '0;
        end else if (req.rd) begin
            unique case (req.addr)
                SEC_ADDR_RST_CTRL: begin
                    // low bits and 7..3 read zero
                    RDATA_O <= {SEC_KEY_READ, SEC_ORDER_LITTLE, 12'h000,
                                chip_req_r, 2'b00};
                end
                SEC_ADDR_PRI_FAULT: RDATA_O <= pri_fault_r;
                SEC_ADDR_PRI_SVC: RDATA_O <= pri_svc_r;
                SEC_ADDR_PRI_TICK: RDATA_O <= pri_tick_r;
                SEC_ADDR_HND_CTRL: RDATA_O <= hnd_r;
                SEC_ADDR_IRQ_STAT: RDATA_O <= {29'h0, ist_r};
                SEC_ADDR_IRQ_EN: RDATA_O <= {29'h0, ien_r};
                default: RDATA_O <= '0;
            endcase
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign CHIP_RESET_REQUEST_O = chip_req_r;
    assign LOCAL_SYSTEM_RESET_O = local_rst_r;
    assign CLEAR_ACTIVE_STATE_O = clr_act_r;
    assign FAULT_ENABLE_O = hnd_r[18:16];
    assign PENDING_O = hnd_r[15:12];
    assign ACTIVE_O = {hnd_r[11:10], hnd_r[8:7], hnd_r[3], hnd_r[1:0]};
    assign PRI_FAULT_O = pri_fault_r;
    assign PRI_SVC_O = pri_svc_r;
    assign PRI_TICK_O = pri_tick_r;
    assign IRQ_O = |(ist_r & ien_r);

    // ****************************************
    // checks
    // ****************************************
    chk_chip_req_set: assert property (
        @(posedge CLK_SYS_I) disable iff (SRST_I)
        do_chip |=> CHIP_RESET_REQUEST_O [*2])
        else $error("chip reset request not raised");

    chk_chip_req_hold: assert property (
        @(posedge CLK_SYS_I) disable iff (SRST_I)
        CHIP_RESET_REQUEST_O |=> CHIP_RESET_REQUEST_O)
        else $error("chip reset request dropped without reset");

    chk_clr_pulse: assert property (
        @(posedge CLK_SYS_I) disable iff (SRST_I)
        do_clr |=> CLEAR_ACTIVE_STATE_O)
        else $error("clear active pulse missing");

    chk_clr_idle: assert property (
        @(posedge CLK_SYS_I) disable iff (SRST_I)
        !do_clr |=> !CLEAR_ACTIVE_STATE_O)
        else $error("clear active pulse without write");

    chk_clr_act: assert property (
        @(posedge CLK_SYS_I) disable iff (SRST_I)
        (clr_act_r && ev.act_set == '0) |=> ACTIVE_O == '0)
        else $error("active state not cleared");

    chk_local_once: assert property (
        @(posedge CLK_SYS_I) disable iff (SRST_I)
        (do_local ##1 !do_local) |=> !LOCAL_SYSTEM_RESET_O)
        else $error("local reset bit did not self-clear");

    chk_local_pulse: assert property (
        @(posedge CLK_SYS_I) disable iff (SRST_I)
        do_local |=> LOCAL_SYSTEM_RESET_O)
        else $error("local reset pulse missing");

    chk_local_idle: assert property (
        @(posedge CLK_SYS_I) disable iff (SRST_I)
        !do_local |=> !LOCAL_SYSTEM_RESET_O)
        else $error("local reset pulse without write");

    chk_key_guard: assert property (
        @(posedge CLK_SYS_I) disable iff (SRST_I)
        (wr_rst && !key_ok && !chip_req_r) |=> !CHIP_RESET_REQUEST_O)
        else $error("reset control written without key");

    chk_key_local: assert property (
        @(posedge CLK_SYS_I) disable iff (SRST_I)
        (wr_rst && !key_ok) |=> !LOCAL_SYSTEM_RESET_O)
        else $error("local reset taken without key");

    chk_key_clr: assert property (
        @(posedge CLK_SYS_I) disable iff (SRST_I)
        (wr_rst && !key_ok) |=> !CLEAR_ACTIVE_STATE_O)
        else $error("clear active taken without key");

    chk_pri_zero: assert property (
        @(posedge CLK_SYS_I) disable iff (SRST_I)
        ((pri_fault_r & ~SEC_PRI_MASK_FAULT) == '0)
        && ((pri_tick_r & ~SEC_PRI_MASK_TICK) == '0))
        else $error("unused priority bits set");

    chk_svc_zero: assert property (
        @(posedge CLK_SYS_I) disable iff (SRST_I)
        (PRI_SVC_O & ~SEC_PRI_MASK_SVC) == '0)
        else $error("unused call priority bits set");

    chk_pri_fault_wr: assert property (
        @(posedge CLK_SYS_I) disable iff (SRST_I)
        wr_pf |=> PRI_FAULT_O == ($past(req.wdata) & SEC_PRI_MASK_FAULT))
        else $error("fault priority word not written");

    chk_pri_svc_wr: assert property (
        @(posedge CLK_SYS_I) disable iff (SRST_I)
        wr_ps |=> PRI_SVC_O == ($past(req.wdata) & SEC_PRI_MASK_SVC))
        else $error("call priority word not written");

    chk_pri_tick_wr: assert property (
        @(posedge CLK_SYS_I) disable iff (SRST_I)
        wr_pt |=> PRI_TICK_O == ($past(req.wdata) & SEC_PRI_MASK_TICK))
        else $error("tick priority word not written");

    chk_pri_fault_hold: assert property (
        @(posedge CLK_SYS_I) disable iff (SRST_I)
        !wr_pf |=> $stable(PRI_FAULT_O))
        else $error("fault priority word changed unwritten");

    chk_pri_svc_hold: assert property (
        @(posedge CLK_SYS_I) disable iff (SRST_I)
        !wr_ps |=> $stable(PRI_SVC_O))
        else $error("call priority word changed unwritten");

    chk_pri_tick_hold: assert property (
        @(posedge CLK_SYS_I) disable iff (SRST_I)
        !wr_pt |=> $stable(PRI_TICK_O))
        else $error("tick priority word changed unwritten");

    chk_hnd_zero: assert property (
        @(posedge CLK_SYS_I) disable iff (SRST_I)
        (hnd_r & ~SEC_HND_MASK) == '0)
        else $error("reserved handler bits set");

    chk_pend_set: assert property (
        @(posedge CLK_SYS_I) disable iff (SRST_I)
        (ev.pend_set != '0) |=> (PENDING_O & $past(ev.pend_set))
        == $past(ev.pend_set))
        else $error("pending event lost");

    chk_pend_wr: assert property (
        @(posedge CLK_SYS_I) disable iff (SRST_I)
        (wr_hnd && ev.pend_set == '0)
        |=> PENDING_O == $past(req.wdata[15:12]))
        else $error("pending bits not written");

    chk_pend_hold: assert property (
        @(posedge CLK_SYS_I) disable iff (SRST_I)
        (!wr_hnd && ev.pend_set == '0) |=> $stable(PENDING_O))
        else $error("pending bits changed without cause");

    chk_act_set: assert property (
        @(posedge CLK_SYS_I) disable iff (SRST_I)
        (ev.act_set != '0) |=> (ACTIVE_O & $past(ev.act_set))
        == $past(ev.act_set))
        else $error("active event lost");

    chk_act_clr: assert property (
        @(posedge CLK_SYS_I) disable iff (SRST_I)
        (ev.act_clr != '0 && ev.act_set == '0 && !wr_hnd)
        |=> (ACTIVE_O & $past(ev.act_clr)) == '0)
        else $error("active clear lost");

    chk_enable_wr: assert property (
        @(posedge CLK_SYS_I) disable iff (SRST_I)
        wr_hnd |=> FAULT_ENABLE_O == $past(req.wdata[18:16]))
        else $error("fault enable not written");

    chk_enable_hold: assert property (
        @(posedge CLK_SYS_I) disable iff (SRST_I)
        !wr_hnd |=> $stable(FAULT_ENABLE_O))
        else $error("fault enable changed unwritten");

    chk_rd_order: assert property (
        @(posedge CLK_SYS_I) disable iff (SRST_I)
        (req.rd && req.addr == SEC_ADDR_RST_CTRL)
        |=> RDATA_O[SEC_BIT_ORDER] == SEC_ORDER_LITTLE)
        else $error("byte order flag not little-endian");

    chk_rd_rsvd: assert property (
        @(posedge CLK_SYS_I) disable iff (SRST_I)
        (req.rd && req.addr == SEC_ADDR_RST_CTRL) |=> RDATA_O[7:3] == '0)
        else $error("reset control reserved bits not zero");

    chk_rd_low: assert property (
        @(posedge CLK_SYS_I) disable iff (SRST_I)
        (req.rd && req.addr == SEC_ADDR_RST_CTRL) |=> RDATA_O[1:0] == '0)
        else $error("self-clearing bits read as set");

    chk_rd_hnd: assert property (
        @(posedge CLK_SYS_I) disable iff (SRST_I)
        (req.rd && req.addr == SEC_ADDR_HND_CTRL)
        |=> (RDATA_O & ~SEC_HND_MASK) == '0)
        else $error("handler reserved bits read as set");

    chk_rd_pri: assert property (
        @(posedge CLK_SYS_I) disable iff (SRST_I)
        (req.rd && req.addr == SEC_ADDR_PRI_TICK)
        |=> (RDATA_O & ~SEC_PRI_MASK_TICK) == '0)
        else $error("priority low bits read as set");

    chk_stat_chip: assert property (
        @(posedge CLK_SYS_I) disable iff (SRST_I)
        do_chip |=> ist_r[SEC_EV_CHIP])
        else $error("chip request status not set");
endmodule : sec_system_exception_control

//--- dv/sec_system_exception_control_tb.sv
// testbench: self-checking register-level test of the exception control
`timescale 1ns/100ps

module sec_system_exception_control_tb;
    import sec_pkg::*;
    logic clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, rd_d = 1'b0;
    logic [31:0] addr = 32'h0, wdata = 32'h0, rdata, d, pf, ps, pt;
    logic [3:0] pend_set = 4'h0, pend;
    logic [6:0] act_set = 7'h0, act_clr = 7'h0, act;
    logic chip_req, loc_rst, clr_act, irq;
    logic [2:0] fen;
    logic [31:0] exp_q[$];
    logic [31:0] amap[3] = '{SEC_ADDR_PRI_FAULT, SEC_ADDR_PRI_SVC,
                             SEC_ADDR_PRI_TICK};
    logic [31:0] mmap[3] = '{SEC_PRI_MASK_FAULT, SEC_PRI_MASK_SVC,
                             SEC_PRI_MASK_TICK};
    int err_total = 0, n_compared = 0, seed = 60873;
    localparam logic [31:0] KEY = {SEC_KEY_WRITE, 16'h0000};
    localparam logic [31:0] RCTL = {SEC_KEY_READ, 16'h0000};

    always #25 clk = ~clk;

    sec_system_exception_control dut (
        .CLK_SYS_I(clk), .SRST_I(srst), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .PEND_SET_I(pend_set),
        .ACT_SET_I(act_set), .ACT_CLR_I(act_clr),
        .CHIP_RESET_REQUEST_O(chip_req), .LOCAL_SYSTEM_RESET_O(loc_rst),
        .CLEAR_ACTIVE_STATE_O(clr_act), .FAULT_ENABLE_O(fen),
        .PENDING_O(pend), .ACTIVE_O(act), .PRI_FAULT_O(pf),
        .PRI_SVC_O(ps), .PRI_TICK_O(pt), .IRQ_O(irq)
    );

    // ****************************************
    // shared tasks and read monitor
    // ****************************************
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h, expected %h", $time,
                     seen, exp);
        end
    endtask : chk

    task wr_reg(input logic [31:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask : wr_reg

    task rd_reg(input logic [31:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        exp_q.push_back(exp);
        @(posedge clk);
        rd <= 1'b0;
    endtask : rd_reg

    always @(posedge clk) rd_d <= rd;
    always @(negedge clk) begin
        if (rd_d === 1'b1) begin
            if (exp_q.size() == 0) chk(rdata, 32'hxxxxxxxx);
            else chk(rdata, exp_q.pop_front());
        end
    end

    task tally_and_finish;
        repeat (3) @(posedge clk);
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        $display("wrong value at %0t: run did not end", $time);
        tally_and_finish();
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        for (int i = 0; i < 3; i++) rd_reg(amap[i], SEC_PRI_RESET);
        rd_reg(SEC_ADDR_HND_CTRL, SEC_HND_RESET);
        rd_reg(SEC_ADDR_RST_CTRL, RCTL);
        rd_reg(32'he000ed28, 32'h0);
        $display("reset values done");
        for (int i = 0; i < 3; i++) begin
            wr_reg(amap[i], 32'hffffffff);
            rd_reg(amap[i], mmap[i]);
            d = $random(seed);
            wr_reg(amap[i], d);
            rd_reg(amap[i], d & mmap[i]);
            chk(i == 0 ? pf : (i == 1 ? ps : pt), d & mmap[i]);
        end
        chk(pt, d & SEC_PRI_MASK_TICK);
        $display("priority done");
        @(posedge clk);
        pend_set <= 4'h5;
        act_set <= 7'h55;
        @(posedge clk);
        pend_set <= 4'h0;
        act_set <= 7'h0;
        act_clr <= 7'h05;
        @(posedge clk);
        act_clr <= 7'h0;
        #1;
        chk(pend, 4'h5);
        chk(act, 7'h50);
        rd_reg(SEC_ADDR_HND_CTRL, 32'h00005900);
        wr_reg(SEC_ADDR_HND_CTRL, 32'hffffffff);
        chk({fen, pend, act}, 14'h3fff);
        rd_reg(SEC_ADDR_HND_CTRL, SEC_HND_MASK);
        wr_reg(SEC_ADDR_RST_CTRL, 32'h00000002);
        chk(clr_act, 1'b0);
        wr_reg(SEC_ADDR_RST_CTRL, KEY | 32'h2);
        chk(clr_act, 1'b1);
        rd_reg(SEC_ADDR_HND_CTRL, SEC_HND_MASK & ~SEC_HND_ACT_MASK);
        chk(act, 7'h00);
        rd_reg(SEC_ADDR_RST_CTRL, RCTL);
        wr_reg(SEC_ADDR_HND_CTRL, 32'h0);
        chk(pend, 4'h0);
        $display("handler state done");
        wr_reg(SEC_ADDR_IRQ_EN, 32'h0);
        wr_reg(SEC_ADDR_RST_CTRL, KEY | 32'h1);
        chk(loc_rst, 1'b1);
        chk(irq, 1'b0);
        rd_reg(SEC_ADDR_RST_CTRL, RCTL);
        rd_reg(SEC_ADDR_IRQ_STAT, 32'h6);
        wr_reg(SEC_ADDR_IRQ_EN, 32'h2);
        chk(irq, 1'b1);
        wr_reg(SEC_ADDR_IRQ_CLR, 32'h6);
        chk(irq, 1'b0);
        rd_reg(SEC_ADDR_IRQ_STAT, 32'h0);
        $display("interrupt done");
        wr_reg(SEC_ADDR_RST_CTRL, KEY | 32'h4);
        chk(chip_req, 1'b1);
        rd_reg(SEC_ADDR_RST_CTRL, RCTL | 32'h4);
        repeat (3) @(posedge clk);
        chk(chip_req, 1'b1);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        #1;
        chk(chip_req, 1'b0);
        rd_reg(SEC_ADDR_RST_CTRL, RCTL);
        $display("chip reset done");
        tally_and_finish();
    end
endmodule : sec_system_exception_control_tb
